// File: logic/acc_sar.sv
package acc_pkg;
    // ==========================================================
    // register map, byte offsets on the bus
    localparam logic [7:0] ACC_OFS_CTRL = 8'h00;
    localparam logic [7:0] ACC_OFS_TIME = 8'h04;
    localparam logic [7:0] ACC_OFS_CONV = 8'h08;
    localparam logic [7:0] ACC_OFS_RES = 8'h0c;
    localparam logic [7:0] ACC_OFS_STAT = 8'h10;
    localparam logic [7:0] ACC_OFS_MASK = 8'h14;
    localparam logic [7:0] ACC_OFS_CSUM = 8'h18;
    // ==========================================================
    // adc_calibration_control fields
    localparam int ACC_BUSY_BIT = 7;
    localparam int ACC_AVG_LO_BIT = 4;
    localparam int ACC_TYPE_BIT = 1;
    localparam int ACC_START_BIT = 0;
    localparam logic [7:0] ACC_CTRL_RST = 8'h00;
    localparam logic [7:0] ACC_CTRL_WMASK = 8'h7f;
    // ==========================================================
    // timing register: [1:0] acquisition clocks - 1, [7:4] divider
    localparam int ACC_ACQ_LO_BIT = 0;
    localparam int ACC_DIV_LO_BIT = 4;
    localparam logic [1:0] ACC_ACQ_RST = 2'h2;
    localparam logic [3:0] ACC_DIV_RST = 4'h0;
    // ==========================================================
    // averaging counts for codes 00, 01, 10, 11
    localparam logic [5:0] ACC_AVG_00 = 6'h0f;
    localparam logic [5:0] ACC_AVG_01 = 6'h01;
    localparam logic [5:0] ACC_AVG_10 = 6'h1f;
    localparam logic [5:0] ACC_AVG_11 = 6'h3f;
    // ==========================================================
    // widths and event bits
    localparam int ACC_RES_W = 12;
    localparam int ACC_SUM_W = 18;
    localparam int ACC_EV_CONV = 0;
    localparam int ACC_EV_CAL = 1;
endpackage : acc_pkg

module acc_sar import acc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic tick_i,
    input wire logic comp_i,
    output logic [ACC_RES_W-1:0] code_o,
    output logic done_o
);
    typedef struct packed {
        logic active;
        logic [3:0] idx;
        logic [ACC_RES_W-1:0] code;
        logic done;
    } acc_sar_type;

    acc_sar_type s_q;
    acc_sar_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (go_i) begin
            s_d.active = 1'b1;
            s_d.idx = 4'(ACC_RES_W - 1);
            s_d.code = '0;
            s_d.code[ACC_RES_W-1] = 1'b1;
        end else if (s_q.active && tick_i) begin
            // comparator high: input still above the trial level
            if (!comp_i) begin
                s_d.code[s_q.idx] = 1'b0;
            end
            if (s_q.idx == 4'h0) begin
                s_d.active = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.idx = s_q.idx - 4'h1;
                s_d.code[s_q.idx - 4'h1] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign code_o = s_q.code;
    assign done_o = s_q.done;
endmodule : acc_sar

// File: logic/acc_core.sv
// What this block does
// - type bit: 0 offset, 1 gain calibration
// - start bit launches selected calibration cycle
// - hardware clears start bit when calibration ends
// - conversion: track phase, then hold with approximation
// - final approximation code latched as result
// - acquisition and conversion timing set by software
// - busy bit 7 high during any operation
// - bits 5:4 pick 15, 1, 31, 63 readings for a calibration
module acc_core import acc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    input wire logic comp_i,
    output logic track_o,
    output logic cal_zero_o,
    output logic cal_full_o,
    output logic [ACC_RES_W-1:0] dac_code_o
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_SYNC, ST_ACQ, ST_CONV
    } acc_state_type;

    typedef struct packed {
        acc_state_type st;
        logic [7:0] ctrl;
        logic [1:0] acq_sel;
        logic [3:0] div_sel;
        logic [5:0] tick_cnt;
        logic tick;
        logic [1:0] acq_cnt;
        logic cal_mode;
        logic [5:0] avg_left;
        logic [ACC_SUM_W-1:0] sum;
        logic [ACC_SUM_W-1:0] cal_sum;
        logic [ACC_RES_W-1:0] result;
        logic [1:0] stat;
        logic [1:0] mask;
        logic irq;
        logic ack;
        logic [31:0] dat;
        logic track;
        logic cal_zero;
        logic cal_full;
        logic sar_go;
        logic comp_s1;
        logic comp_s2;
    } acc_core_type;

    acc_core_type s_q;
    acc_core_type s_d;
    logic [ACC_RES_W-1:0] sar_code;
    logic sar_done;

    function automatic logic [5:0] avg_count(input logic [1:0] sel);
        logic [5:0] n;
        unique case (sel)
            2'b00: n = ACC_AVG_00;
            2'b01: n = ACC_AVG_01;
            2'b10: n = ACC_AVG_10;
            2'b11: n = ACC_AVG_11;
        endcase
        return n;
    endfunction : avg_count

    acc_sar u_sar (
        .clk_i(clk_i),
        .rst_i(rst_i),
        // first trial loads at the edge tracking ends, so the synchroniser
        // has a full adc clock before the first decision
        .go_i(s_d.sar_go),
        .tick_i(s_q.tick),
        .comp_i(s_q.comp_s2),
        .code_o(sar_code),
        .done_o(sar_done)
    );

    always_comb begin
        logic req;
        logic wr;
        logic [1:0] ev;
        logic [1:0] clr;
        logic start_cal;
        logic start_conv;
        req = cyc_i && stb_i && !s_q.ack;
        wr = req && we_i && sel_i[0];
        ev = 2'b00;
        clr = 2'b00;
        start_cal = 1'b0;
        start_conv = 1'b0;
        s_d = s_q;
        s_d.comp_s1 = comp_i;
        s_d.comp_s2 = s_q.comp_s1;
        s_d.sar_go = 1'b0;
        // ======================================================
        // bus slave: one wait state, unmapped reads return zero
        s_d.ack = req;
        s_d.dat = '0;
        if (req && !we_i) begin
            unique case (adr_i)
                ACC_OFS_CTRL: s_d.dat = {24'h0, s_q.ctrl};
                ACC_OFS_TIME: s_d.dat = {24'h0, s_q.div_sel, 2'b00,
                    s_q.acq_sel};
                ACC_OFS_RES: s_d.dat = {20'h0, s_q.result};
                ACC_OFS_STAT: s_d.dat = {30'h0, s_q.stat};
                ACC_OFS_MASK: s_d.dat = {30'h0, s_q.mask};
                ACC_OFS_CSUM: s_d.dat = {14'h0, s_q.cal_sum};
                default: s_d.dat = '0;
            endcase
        end
        if (wr) begin
            unique case (adr_i)
                ACC_OFS_CTRL: begin
                    // busy is read-only; a start while busy is dropped
                    if (s_q.st == ST_IDLE) begin
                        s_d.ctrl = (dat_i[7:0] & ACC_CTRL_WMASK);
                        start_cal = dat_i[ACC_START_BIT];
                    end
                end
                ACC_OFS_TIME: begin
                    s_d.acq_sel = dat_i[ACC_ACQ_LO_BIT +: 2];
                    s_d.div_sel = dat_i[ACC_DIV_LO_BIT +: 4];
                end
                ACC_OFS_CONV: start_conv = dat_i[0] && (s_q.st == ST_IDLE);
                ACC_OFS_STAT: clr = dat_i[1:0];
                ACC_OFS_MASK: s_d.mask = dat_i[1:0];
                default: ;
            endcase
        end
        // ======================================================
        // adc clock: one tick every (div_sel+1)*4 system clocks,
        // so the synchronised comparator has settled at each tick
        s_d.tick = 1'b0;
        if (s_q.st == ST_IDLE) begin
            s_d.tick_cnt = '0;
        end else if (s_q.tick_cnt == {s_q.div_sel, 2'b11}) begin
            s_d.tick_cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 6'h1;
        end
        // ======================================================
        // sequencer
        unique case (s_q.st)
            ST_IDLE: begin
                if (start_cal || start_conv) begin
                    s_d.st = ST_SYNC;
                    s_d.cal_mode = start_cal;
                    s_d.ctrl[ACC_BUSY_BIT] = 1'b1;
                    s_d.avg_left = start_conv ? 6'h01 :
                        avg_count(dat_i[ACC_AVG_LO_BIT +: 2]);
                    s_d.sum = '0;
                    // calibration input: ground or full reference
                    s_d.cal_zero = start_cal &&
                        !dat_i[ACC_TYPE_BIT];
                    s_d.cal_full = start_cal &&
                        dat_i[ACC_TYPE_BIT];
                end
            end
            ST_SYNC: begin
                if (s_q.tick) begin
                    s_d.st = ST_ACQ;
                    s_d.track = 1'b1;
                    s_d.acq_cnt = s_q.acq_sel;
                end
            end
            ST_ACQ: begin
                if (s_q.tick) begin
                    if (s_q.acq_cnt == 2'h0) begin
                        s_d.st = ST_CONV;
                        s_d.track = 1'b0;
                        s_d.sar_go = 1'b1;
                    end else begin
                        s_d.acq_cnt = s_q.acq_cnt - 2'h1;
                    end
                end
            end
            ST_CONV: begin
                if (sar_done) begin
                    s_d.result = sar_code;
                    s_d.sum = s_q.sum + ACC_SUM_W'(sar_code);
                    if (s_q.avg_left == 6'h01) begin
                        s_d.st = ST_IDLE;
                        s_d.ctrl[ACC_BUSY_BIT] = 1'b0;
                        s_d.cal_zero = 1'b0;
                        s_d.cal_full = 1'b0;
                        if (s_q.cal_mode) begin
                            s_d.ctrl[ACC_START_BIT] = 1'b0;
                            s_d.cal_sum = s_q.sum + ACC_SUM_W'(sar_code);
                            ev[ACC_EV_CAL] = 1'b1;
                        end else begin
                            ev[ACC_EV_CONV] = 1'b1;
                        end
                    end else begin
                        s_d.avg_left = s_q.avg_left - 6'h1;
                        s_d.st = ST_SYNC;
                    end
                end
            end
        endcase
        // set wins over a write-one clear in the same cycle
        s_d.stat = (s_q.stat & ~clr) | ev;
        s_d.irq = |(s_d.stat & s_d.mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{st: ST_IDLE, ctrl: ACC_CTRL_RST, acq_sel: ACC_ACQ_RST,
                div_sel: ACC_DIV_RST, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign dat_o = s_q.dat;
    assign ack_o = s_q.ack;
    assign irq_o = s_q.irq;
    assign track_o = s_q.track;
    assign cal_zero_o = s_q.cal_zero;
    assign cal_full_o = s_q.cal_full;
    // trial code leaves straight from the approximation register: an extra
    // stage here would eat the comparator's settling margin at div 0
    assign dac_code_o = sar_code;

    // ==========================================================
    // checks
    a_busy_state: assert property (@(posedge clk_i)
        disable iff (rst_i)
        s_q.ctrl[ACC_BUSY_BIT] == (s_q.st != ST_IDLE))
        else $error("busy flag disagrees with sequencer");
    a_start_cleared: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $fell(s_q.ctrl[ACC_BUSY_BIT]) && s_q.cal_mode
        |-> !s_q.ctrl[ACC_START_BIT] && s_q.stat[ACC_EV_CAL])
        else $error("start bit not cleared after calibration");
    a_track_phase: assert property (@(posedge clk_i)
        disable iff (rst_i)
        s_q.track == (s_q.st == ST_ACQ))
        else $error("track output outside acquisition");
    a_hold_after: assert property (@(posedge clk_i)
        disable iff (rst_i)
        s_q.sar_go |-> $past(s_q.st) == ST_ACQ && !s_q.track)
        else $error("approximation started without tracking");
    a_result_latch: assert property (@(posedge clk_i)
        disable iff (rst_i)
        sar_done && s_q.st == ST_CONV |=> s_q.result == $past(sar_code))
        else $error("result not latched from approximation");
    a_cal_select: assert property (@(posedge clk_i)
        disable iff (rst_i)
        s_q.cal_zero |-> !s_q.ctrl[ACC_TYPE_BIT] && !s_q.cal_full
            && s_q.cal_mode)
        else $error("offset select with gain type");
    a_avg_count: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $rose(s_q.ctrl[ACC_BUSY_BIT]) && s_q.cal_mode
        |-> s_q.avg_left == avg_count(s_q.ctrl[ACC_AVG_LO_BIT +: 2]))
        else $error("averaging count does not match field");
    a_acq_length: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $rose(s_q.track) |-> s_q.acq_cnt == s_q.acq_sel)
        else $error("acquisition length not from timing register");
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.irq == |(s_q.stat & s_q.mask))
        else $error("interrupt level wrong");
endmodule : acc_core

// File: sim/acc_core_bench.sv
module acc_core_bench import acc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // stimulus and monitor state
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic comp_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o, irq_o, track_o, cal_zero_o, cal_full_o;
    logic [ACC_RES_W-1:0] dac_code_o;
    logic [ACC_RES_W-1:0] dac_p = 12'h000;
    logic [11:0] target = 12'h5a3;
    logic trk_p = 1'b0;
    int bad_count = 0;
    int checks = 0;
    int rises = 0, run = 0, last_run = 0, ovl = 0;

    acc_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
        .comp_i(comp_i), .track_o(track_o), .cal_zero_o(cal_zero_o),
        .cal_full_o(cal_full_o), .dac_code_o(dac_code_o));

    always #50 clk_i = ~clk_i;

    // ==========================================================
    // comparator: input sits half a step above target, so the
    // search lands exactly on target whatever the tie handling
    always @(posedge clk_i) begin
        comp_i <= (dac_code_o <= target);
        if (track_o === 1'b1 && !trk_p) rises++;
        if (track_o === 1'b1) run++;
        else begin
            if (trk_p) last_run = run;
            run = 0;
        end
        if (dac_code_o !== dac_p && track_o && trk_p) ovl++;
        trk_p = track_o;
        dac_p = dac_code_o;
    end

    // ==========================================================
    // helpers
    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= d;
        // no cycle limit here: a missing ack is left to the watchdog
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
        // ack stands for one cycle only
        chk("bus ack", 32'h0, {31'h0, ack_o});
    endtask : wb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask : rd

    task wait_idle;
        logic [31:0] q;
        int n;
        n = 0;
        q = 32'h80;
        while (q[ACC_BUSY_BIT] === 1'b1 && n < 5000) begin
            rd(ACC_OFS_CTRL, q);
            n++;
        end
        chk("busy clear", 32'h0, {24'h0, q[7], 7'h0});
    endtask : wait_idle

    // ==========================================================
    // scenarios
    task t_reset;
        logic [31:0] q;
        rd(ACC_OFS_CTRL, q);
        chk("ctrl reset", {24'h0, ACC_CTRL_RST}, q);
        rd(ACC_OFS_TIME, q);
        chk("timing reset", {24'h0, ACC_DIV_RST, 2'h0, ACC_ACQ_RST}, q);
        rd(8'h1c, q);
        chk("unmapped read", 32'h0, q);
        chk("irq idle", 32'h0, {31'h0, irq_o});
        $display("test reset done");
    endtask : t_reset

    task t_conv(input logic [7:0] tim, input int len);
        logic [31:0] q;
        int r0;
        wr(ACC_OFS_TIME, {24'h0, tim});
        wr(ACC_OFS_MASK, 32'h1);
        r0 = rises;
        wr(ACC_OFS_CONV, 32'h1);
        rd(ACC_OFS_CTRL, q);
        chk("busy in conversion", 32'h80, q & 32'h80);
        wait_idle;
        chk("track phases", 32'h1, rises - r0);
        chk("sar moved in track", 32'h0, ovl);
        chk("track length", len, last_run);
        rd(ACC_OFS_RES, q);
        chk("result", {20'h0, target}, q);
        rd(ACC_OFS_STAT, q);
        chk("conv status", 32'h1, q);
        chk("irq raised", 32'h1, {31'h0, irq_o});
        wr(ACC_OFS_STAT, 32'h1);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        $display("test conversion %h done", tim);
    endtask : t_conv

    task t_cal(input logic [1:0] avg, input logic typ, input int n);
        logic [31:0] q;
        logic [7:0] c;
        int r0;
        c = {2'h0, avg, 1'b0, 1'b1, typ, 1'b1};
        r0 = rises;
        wr(ACC_OFS_MASK, 32'h2);
        wr(ACC_OFS_CTRL, {24'h0, c});
        chk("offset select", {31'h0, !typ}, {31'h0, cal_zero_o});
        chk("gain select", {31'h0, typ}, {31'h0, cal_full_o});
        rd(ACC_OFS_CTRL, q);
        chk("ctrl running", {24'h0, 8'h80 | c}, q);
        // a write while busy must leave the type untouched
        wr(ACC_OFS_CTRL, {24'h0, c[7:2], ~typ, 1'b0});
        wait_idle;
        rd(ACC_OFS_CTRL, q);
        chk("start cleared", {24'h0, c & 8'hfe}, q);
        chk("readings", n, rises - r0);
        rd(ACC_OFS_CSUM, q);
        chk("cal sum", n * target, q);
        rd(ACC_OFS_STAT, q);
        chk("cal status", 32'h2, q);
        chk("cal irq", 32'h1, {31'h0, irq_o});
        wr(ACC_OFS_STAT, 32'h2);
        $display("test calibration %b %b done", avg, typ);
    endtask : t_cal

    task stop_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    // ==========================================================
    // sequence and watchdog
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_conv(8'h00, 4);
        t_conv(8'h13, 32);
        t_cal(2'b01, 1'b0, 1);
        t_cal(2'b00, 1'b1, 15);
        t_cal(2'b10, 1'b0, 31);
        t_cal(2'b11, 1'b1, 63);
        stop_test;
    end

    initial begin
        repeat (40000) @(posedge clk_i);
        bad_count++;
        $display("[FAIL] watchdog expected done seen hang");
        stop_test;
    end
endmodule : acc_core_bench
